// File: shared/cpdec_defs.svh
`ifndef CPDEC_DEFS_SVH
`define CPDEC_DEFS_SVH
// ==========================================================
// opcodes
`define CPDEC_OP_TEST_DIR  8'h3d
`define CPDEC_OP_TEST_ACC  8'h4d
`define CPDEC_OP_TEST_IDX  8'h5d
`define CPDEC_OP_TEST_BYTE 8'h6d
`define CPDEC_OP_TEST_IX   8'h7d
`define CPDEC_OP_COPY_XA   8'h9f
`define CPDEC_OP_WAIT      8'h8f
// ==========================================================
// addressing-mode columns (high opcode digit)
`define CPDEC_COL_FULL     4'hc
`define CPDEC_COL_WORD     4'hd
`define CPDEC_COL_BYTE     4'he
`define CPDEC_COL_IX       4'hf
`define CPDEC_COL_DIR_RMW  4'h3
`define CPDEC_COL_DIR_REG  4'hb
`define CPDEC_COL_BYTE_RMW 4'h6
`define CPDEC_COL_IX_RMW   4'h7
// ==========================================================
// condition code bit positions
`define CPDEC_CC_C         0
`define CPDEC_CC_Z         1
`define CPDEC_CC_N         2
`define CPDEC_CC_I         3
`define CPDEC_CC_H         4
`define CPDEC_CC_RESET     5'h08
`define CPDEC_SIGN_BIT     7
// ==========================================================
// cycle counts
`define CPDEC_CYC_COPY     3'h2
`define CPDEC_CYC_ONE      3'h1
`endif

// File: shared/cpdec_pkg.sv
package cpdec_pkg;
  typedef enum logic [2:0] {
    CPDEC_ST_FETCH,
    CPDEC_ST_OPND_HI,
    CPDEC_ST_OPND_LO,
    CPDEC_ST_EXEC,
    CPDEC_ST_HALT
  } cpdec_state_e;

  typedef enum logic [2:0] {
    CPDEC_AM_IMPL,
    CPDEC_AM_DIR,
    CPDEC_AM_FULL,
    CPDEC_AM_IX,
    CPDEC_AM_BYTE,
    CPDEC_AM_WORD
  } cpdec_mode_e;
endpackage : cpdec_pkg

// File: shared/cpdec_ea_if.sv
`timescale 1ns/10ps
// ==========================================================
// effective address request and answer
interface cpdec_ea_if;
  import cpdec_pkg::*;
  cpdec_mode_e mode;
  logic [7:0]  hi;
  logic [7:0]  lo;
  logic [7:0]  idx;
  logic [15:0] ea;
  modport core (output mode, output hi, output lo, output idx, input ea);
  modport calc (input mode, input hi, input lo, input idx, output ea);
endinterface : cpdec_ea_if

// File: core/cpdec_ea.sv
`timescale 1ns/10ps
`include "cpdec_defs.svh"
// ==========================================================
// effective address former
module cpdec_ea
  import cpdec_pkg::*;
(
  cpdec_ea_if.calc ea_port
);
  always_comb
  begin
    unique case (ea_port.mode)
      CPDEC_AM_FULL: ea_port.ea = {ea_port.hi, ea_port.lo};                       // [RULE6]
      CPDEC_AM_WORD: ea_port.ea = {ea_port.hi, ea_port.lo} + {8'h00, ea_port.idx}; // [RULE5]
      CPDEC_AM_BYTE: ea_port.ea = {8'h00, ea_port.hi} + {8'h00, ea_port.idx};     // [RULE7]
      CPDEC_AM_IX:  ea_port.ea = {8'h00, ea_port.idx};
      CPDEC_AM_DIR: ea_port.ea = {8'h00, ea_port.hi};
      default:      ea_port.ea = 16'h0000;
    endcase
  end
endmodule : cpdec_ea

// File: core/cpdec_core.sv
// Operation
// RULE1: test sets N and Z from operand versus zero; H, I, C kept; five forms.
// RULE2: index-to-accumulator copy loads A from X, flags untouched, two cycles.
// RULE3: wait clears interrupt mask, halts CPU clock, other flags unchanged.
// RULE4: opcode high digit selects addressing column; F, E, D: no, byte, word offset.
// RULE5: word-offset indexed fetches high then low offset, adds index.
// RULE6: full-address mode fetches high then low address, used directly.
// RULE7: byte-offset indexed fetches one offset byte, adds index register.
`timescale 1ns/10ps
`include "cpdec_defs.svh"
module cpdec_core
  import cpdec_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        fetch_valid,
  input  wire logic [7:0]  fetch_byte,
  input  wire logic [7:0]  mem_data,
  input  wire logic [7:0]  index_in,
  input  wire logic        irq,
  output logic             fetch_req,
  output logic [15:0]      ea,
  output logic             ea_valid,
  output logic [7:0]       acc,
  output logic [4:0]       condition_code_reg,
  output logic             cpu_clock_halt,
  output logic [7:0]       opcode
);
  typedef struct packed {
    cpdec_state_e st;
    cpdec_mode_e  mode;
    logic [7:0]   op;
    logic [7:0]   hi;
    logic [7:0]   lo;
    logic [2:0]   cyc;
    logic [15:0]  ea;
    logic         ea_valid;
    logic [7:0]   acc;
    logic [4:0]   cc;
    logic         halt;
    logic         freq;
  } cpdec_reg_s;

  cpdec_reg_s r;
  cpdec_reg_s next_r;
  cpdec_ea_if ea_bus ();

  // ==========================================================
  // mode decode
  function automatic cpdec_mode_e cpdec_mode_of(input logic [7:0] op);
    unique case (op[7:4])                                                        // [RULE4]
      `CPDEC_COL_IX:       cpdec_mode_of = CPDEC_AM_IX;
      `CPDEC_COL_BYTE:     cpdec_mode_of = CPDEC_AM_BYTE;
      `CPDEC_COL_WORD:     cpdec_mode_of = CPDEC_AM_WORD;
      `CPDEC_COL_FULL:     cpdec_mode_of = CPDEC_AM_FULL;
      `CPDEC_COL_DIR_RMW,
      `CPDEC_COL_DIR_REG:  cpdec_mode_of = CPDEC_AM_DIR;
      `CPDEC_COL_BYTE_RMW: cpdec_mode_of = CPDEC_AM_BYTE;
      `CPDEC_COL_IX_RMW:   cpdec_mode_of = CPDEC_AM_IX;
      default:             cpdec_mode_of = CPDEC_AM_IMPL;
    endcase
  endfunction : cpdec_mode_of

  function automatic logic [4:0] cpdec_nz(input logic [4:0] cc, input logic [7:0] v);
    logic [4:0] t;
    t = cc;
    t[`CPDEC_CC_N] = v[`CPDEC_SIGN_BIT];
    t[`CPDEC_CC_Z] = (v == 8'h00);
    cpdec_nz = t;
  endfunction : cpdec_nz

  assign ea_bus.mode = r.mode;
  assign ea_bus.hi   = r.hi;
  assign ea_bus.lo   = r.lo;
  assign ea_bus.idx  = index_in;

  cpdec_ea u_ea (
    .ea_port (ea_bus.calc)
  );

  // ==========================================================
  // sequencer
  always_comb
  begin
    next_r = r;
    next_r.ea_valid = 1'b0;
    unique case (r.st)
      CPDEC_ST_FETCH:
      begin
        next_r.freq = 1'b1;
        if (fetch_valid)
        begin
          next_r.op   = fetch_byte;
          next_r.mode = cpdec_mode_of(fetch_byte);
          next_r.cyc  = `CPDEC_CYC_ONE;
          unique case (cpdec_mode_of(fetch_byte))
            CPDEC_AM_IMPL, CPDEC_AM_IX:
            begin
              next_r.st   = CPDEC_ST_EXEC;
              next_r.freq = 1'b0;
            end
            default: next_r.st = CPDEC_ST_OPND_HI;
          endcase
        end
      end
      CPDEC_ST_OPND_HI:
      begin
        if (fetch_valid)
        begin
          next_r.hi = fetch_byte;                                               // [RULE5] [RULE6] [RULE7]
          if (r.mode == CPDEC_AM_FULL || r.mode == CPDEC_AM_WORD)
            next_r.st = CPDEC_ST_OPND_LO;
          else
          begin
            next_r.st   = CPDEC_ST_EXEC;
            next_r.freq = 1'b0;
          end
        end
      end
      CPDEC_ST_OPND_LO:
      begin
        if (fetch_valid)
        begin
          next_r.lo   = fetch_byte;                                             // [RULE5] [RULE6]
          next_r.st   = CPDEC_ST_EXEC;
          next_r.freq = 1'b0;
        end
      end
      CPDEC_ST_EXEC:
      begin
        next_r.ea       = ea_bus.ea;
        next_r.ea_valid = (r.mode != CPDEC_AM_IMPL);
        unique case (r.op)
          `CPDEC_OP_TEST_ACC: next_r.cc = cpdec_nz(r.cc, r.acc);                // [RULE1]
          `CPDEC_OP_TEST_IDX: next_r.cc = cpdec_nz(r.cc, index_in);             // [RULE1]
          `CPDEC_OP_TEST_DIR, `CPDEC_OP_TEST_BYTE, `CPDEC_OP_TEST_IX:
            next_r.cc = cpdec_nz(r.cc, mem_data);                               // [RULE1]
          `CPDEC_OP_COPY_XA:
          begin
            next_r.acc = index_in;                                              // [RULE2]
          end
          `CPDEC_OP_WAIT:
          begin
            next_r.cc[`CPDEC_CC_I] = 1'b0;                                      // [RULE3]
            next_r.halt = 1'b1;                                                 // [RULE3]
          end
          default: next_r.cc = r.cc;
        endcase
        if (r.op == `CPDEC_OP_COPY_XA && r.cyc != `CPDEC_CYC_COPY)
          next_r.cyc = r.cyc + `CPDEC_CYC_ONE;                                  // [RULE2]
        else if (r.op == `CPDEC_OP_WAIT)
          next_r.st = CPDEC_ST_HALT;
        else
        begin
          next_r.st   = CPDEC_ST_FETCH;
          next_r.freq = 1'b1;
        end
        if (r.op == `CPDEC_OP_COPY_XA && r.cyc != `CPDEC_CYC_COPY)
          next_r.acc = r.acc;
      end
      CPDEC_ST_HALT:
      begin
        // clock stays stopped until an interrupt wakes the core
        if (irq)
        begin
          next_r.halt = 1'b0;
          next_r.st   = CPDEC_ST_FETCH;
          next_r.freq = 1'b1;
        end
      end
      default: next_r.st = CPDEC_ST_FETCH;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      r      <= '0;
      r.st   <= CPDEC_ST_FETCH;
      r.mode <= CPDEC_AM_IMPL;
      r.cc   <= `CPDEC_CC_RESET;
      r.freq <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign fetch_req          = r.freq;
  assign ea                 = r.ea;
  assign ea_valid           = r.ea_valid;
  assign acc                = r.acc;
  assign condition_code_reg = r.cc;
  assign cpu_clock_halt     = r.halt;
  assign opcode             = r.op;
endmodule : cpdec_core

// File: verification/cpdec_mem_model.sv
`timescale 1ns/10ps
// ==========================================
// program byte source
module cpdec_mem_model
(
  input  wire logic       clock,
  input  wire logic       fetch_req,
  output logic            fetch_valid,
  output logic [7:0]      fetch_byte
);
  logic [7:0] q[$];
  initial
  begin
    fetch_valid = 1'b0;
    fetch_byte  = 8'h00;
  end
  // a byte leaves only at the edge that takes it
  always @(posedge clock)
    if (fetch_req && fetch_valid)
      void'(q.pop_front());
  // idle bus toggles so a stale byte is never mistaken for a fresh one
  always @(negedge clock)
  begin
    fetch_valid <= (q.size() != 0);
    fetch_byte  <= (q.size() != 0) ? q[0] : ~fetch_byte;
  end
endmodule : cpdec_mem_model

// File: verification/cpdec_core_chk.sv
`timescale 1ns/10ps
// ==========================================
// decode checks
module cpdec_core_chk
  import cpdec_pkg::*;
(
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        fetch_valid,
  input wire logic [7:0]  fetch_byte,
  input wire logic [7:0]  mem_data,
  input wire logic [7:0]  index_in,
  input wire logic        irq,
  input wire logic        fetch_req,
  input wire logic [15:0] ea,
  input wire logic        ea_valid,
  input wire logic [7:0]  acc,
  input wire logic [4:0]  condition_code_reg,
  input wire logic        cpu_clock_halt,
  input wire logic [7:0]  opcode
);
  logic [7:0] b1;
  logic [7:0] b0;
  logic [4:0] cc;
  logic       tk;
  assign cc = condition_code_reg;
  assign tk = fetch_req && fetch_valid;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // last two program bytes taken
  always_ff @(posedge clock)
    if (tk)
    begin
      b1 <= b0;
      b0 <= fetch_byte;
    end
  AST_TEST_KEEP: assert property (opcode[3:0] == 4'hd && $changed(cc) |->
    $stable(cc[4]) && $stable(cc[3]) && $stable(cc[0])) else $error("test moved H, I or C");
  AST_TEST_NZ: assert property (ea_valid && opcode[3:0] == 4'hd |->
    cc[2:1] == {$past(mem_data) >= 8'h80, $past(mem_data) == 8'h00}) else $error("test N/Z");
  AST_COPY_FLAGS: assert property ($changed(acc) |-> $stable(cc))
    else $error("copy altered flags");
  AST_COPY_ACC: assert property (tk && fetch_byte == 8'h9f |-> ##[2:5] acc == index_in)
    else $error("copy did not load accumulator");
  AST_WAIT_FLAGS: assert property ($rose(cpu_clock_halt) |->
    !cc[3] && $stable(cc[4]) && $stable(cc[2:0])) else $error("wait flags wrong");
  AST_WAIT_HALT: assert property (tk && fetch_byte == 8'h8f |-> ##[1:4] cpu_clock_halt)
    else $error("wait did not halt");
  AST_HALT_NOFETCH: assert property (cpu_clock_halt |-> !fetch_req)
    else $error("fetch while halted");
  AST_EA_FULL: assert property (ea_valid && opcode[7:4] == 4'hc |-> ea == {b1, b0})
    else $error("full address wrong");
  AST_EA_WORD: assert property (ea_valid && opcode[7:4] == 4'hd |->
    ea == {b1, b0} + {8'h00, index_in}) else $error("word offset address wrong");
  AST_EA_BYTE: assert property (ea_valid && (opcode[7:4] == 4'he || opcode == 8'h6d) |->
    ea == {8'h00, b0} + {8'h00, index_in}) else $error("byte offset address wrong");
  AST_EA_NOOFS: assert property (ea_valid && (opcode[7:4] == 4'hf || opcode == 8'h7d) |->
    ea == {8'h00, index_in}) else $error("no offset address wrong");
  cover property (ea_valid && opcode[7:4] == 4'hd);
  cover property ($rose(cpu_clock_halt));
  cover property ($changed(acc));
  cover property (ea_valid && opcode == 8'h3d);
endmodule : cpdec_core_chk
bind cpdec_core cpdec_core_chk chk (.*);

// File: verification/testbench.sv
`timescale 1ns/10ps
// ==========================================
// decoder bench
module testbench;
  import cpdec_pkg::*;
  logic        clock;
  logic        nrst;
  logic [7:0]  mem_data;
  logic [7:0]  index_in;
  logic        irq;
  logic        fetch_valid;
  logic [7:0]  fetch_byte;
  logic        fetch_req;
  logic [15:0] ea;
  logic        ea_valid;
  logic [7:0]  acc;
  logic [4:0]  condition_code_reg;
  logic        cpu_clock_halt;
  logic [7:0]  opcode;
  logic [4:0]  cc0;
  int          errors;
  int          num_checks;
  int          cycles;
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  cpdec_core dut (.*);
  cpdec_mem_model mem (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (errors == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask : idle
  task automatic do_ea(input logic [7:0] op, input int n, input logic [7:0] hi,
                       input logic [7:0] lo, input logic [15:0] exp);
    int k;
    k = 0;
    mem.q.push_back(op);
    if (n > 0) mem.q.push_back(hi);
    if (n > 1) mem.q.push_back(lo);
    idle(1);
    while (ea_valid !== 1'b1 && k < 20)
    begin
      idle(1);
      k++;
    end
    chk(ea, exp);
  endtask : do_ea
  task automatic t_tst();
    cc0 = condition_code_reg;
    mem_data = 8'h80;
    do_ea(8'h6d, 1, 8'h10, 8'h00, 16'h0045);
    chk(condition_code_reg, {cc0[4:3], 2'b10, cc0[0]});
    mem_data = 8'h00;
    do_ea(8'h7d, 0, 8'h00, 8'h00, 16'h0035);
    chk(condition_code_reg, {cc0[4:3], 2'b01, cc0[0]});
    mem.q.push_back(8'h5d);
    idle(6);
    chk(condition_code_reg, {cc0[4:3], 2'b00, cc0[0]});
    mem.q.push_back(8'h4d);
    idle(6);
    chk(condition_code_reg, {cc0[4:3], 2'b01, cc0[0]});
    mem_data = 8'hff;
    do_ea(8'h3d, 1, 8'h44, 8'h00, 16'h0044);
    chk(condition_code_reg, {cc0[4:3], 2'b10, cc0[0]});
  endtask : t_tst
  task automatic t_modes();
    do_ea(8'hc6, 2, 8'h12, 8'h34, 16'h1234);
    do_ea(8'hd6, 2, 8'h12, 8'hf0, 16'h1325);
    do_ea(8'he6, 1, 8'hf0, 8'h00, 16'h0125);
    do_ea(8'hf6, 0, 8'h00, 8'h00, 16'h0035);
  endtask : t_modes
  task automatic t_copy();
    int k;
    k = 0;
    cc0 = condition_code_reg;
    mem.q.push_back(8'h9f);
    repeat (6)
    begin
      idle(1);
      if (fetch_req !== 1'b1) k++;
    end
    chk(k, 2);
    chk(acc, 8'h35);
    chk(condition_code_reg, cc0);
  endtask : t_copy
  task automatic t_wait();
    cc0 = condition_code_reg;
    mem.q.push_back(8'h8f);
    idle(5);
    chk(cpu_clock_halt, 1'b1);
    chk(condition_code_reg, cc0 & 5'h17);
    irq = 1'b1;
    idle(2);
    chk(fetch_req, 1'b1);
    irq = 1'b0;
  endtask : t_wait
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      end_sim();
    end
  end
  initial
  begin
    nrst = 1'b0;
    mem_data = 8'h00;
    index_in = 8'h35;
    irq = 1'b0;
    errors = 0;
    num_checks = 0;
    cycles = 0;
    idle(4);
    nrst = 1'b1;
    t_tst();
    t_modes();
    t_copy();
    t_wait();
    end_sim();
  end
endmodule : testbench
